/* File: bench/sbd_peer.sv */
`timescale 1ns/1ps
module sbd_peer (
    input wire logic pclk,
    input wire logic txd_out,
    input wire logic txd_oe,
    output logic     rxd
);
    int         blen = 16;
    int         stlen;
    logic [8:0] cap[$];
    initial rxd = 1'b1;
    task automatic send(input logic [7:0] b, input int bl);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            rxd <= f[i];
            repeat (bl) @(posedge pclk);
        end
    endtask : send
    // frame catcher
    always
    begin : mon
        logic [9:0] f;
        @(negedge txd_out iff txd_oe === 1'b1);
        stlen = 0;
        while (txd_out === 1'b0 && stlen < blen)
        begin
            @(posedge pclk);
            #1;
            stlen++;
        end
        for (int i = 1; i < 10; i++)
        begin
            repeat (i == 1 ? blen / 2 : blen) @(posedge pclk);
            f[i] = txd_out;
        end
        cap.push_back(f[9:1]);
    end
endmodule : sbd_peer

/* File: bench/sbd_top_chk.sv */
`timescale 1ns/1ps
`include "sbd_regs.svh"
module sbd_top_chk #(
    parameter int AW = 12
) (
    input wire logic          pclk,
    input wire logic          presetn,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0]   pwdata,
    input wire logic [31:0]   prdata,
    input wire logic          pready,
    input wire logic          txd_out,
    input wire logic          txd_oe,
    input wire logic          irq
);
    logic [7:0]  ctl_q;
    logic [7:0]  bd_q;
    logic [2:0]  ev_q;
    logic        lv_q;
    logic [15:0] run_q;
    logic        wr;
    assign wr = psel && penable && pready && pwrite;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // register shadows
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctl_q <= 8'h00;
            bd_q  <= 8'h00;
            ev_q  <= 3'h0;
        end
        else if (wr)
        begin
            if (paddr == AW'(`SBD_IDX_CTRL * 4))
            begin
                ctl_q <= pwdata[7:0];
                ev_q  <= ev_q | {pwdata[3], 1'b0, pwdata[0]};
            end
            if (paddr == AW'(`SBD_IDX_BAUD * 4))
                bd_q <= pwdata[7:0];
            if (paddr == AW'(`SBD_IDX_DATA * 4))
                ev_q[1] <= 1'b1;
        end
    end
    // line run length
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lv_q  <= 1'b1;
            run_q <= 16'h0000;
        end
        else
        begin
            lv_q  <= txd_out;
            run_q <= (txd_out == lv_q) ? run_q + 16'h0001 : 16'h0000;
        end
    end
    AST_IRQ_MASK: assert property (ctl_q[7:4] == 4'h0 |-> !irq)
        else $error("irq masked");
    AST_IRQ_TX: assert property ((ctl_q[7] || ctl_q[6]) && !ev_q[1] |-> irq)
        else $error("irq missing");
    AST_OE_ON: assert property (ctl_q[3] |-> ##[0:2] txd_oe)
        else $error("pin not owned");
    AST_OE_OFF: assert property (!ev_q[2] |-> !txd_oe)
        else $error("pin owned early");
    AST_IDLE_HI: assert property (!ev_q[2] |-> txd_out)
        else $error("line low");
    AST_WAIT_BIT: assert property ($rose(ctl_q[3]) && bd_q == 8'h00
        && txd_out && run_q >= 16'd2 |-> txd_out [*8] ##1 txd_out [*8])
        else $error("early start");
    AST_NO_BRK: assert property (!ev_q[0] && bd_q == 8'h00 && !txd_out
        |-> run_q <= 16'd144)
        else $error("stray break");
    AST_PRD_HI: assert property (pready |-> prdata[31:8] == 24'h00_0000)
        else $error("prdata high bits");
    cover property (wr && ev_q[2]);
    cover property ($rose(irq));
    cover property ($fell(txd_out));
endmodule : sbd_top_chk

/* File: bench/sbd_top_test.sv */
`timescale 1ns/1ps
module sbd_top_test;
    localparam logic [11:0] A_DP = 12'h144;
    localparam logic [11:0] A_BD = 12'h148;
    localparam logic [11:0] A_CT = 12'h150;
    logic        pclk, presetn, ce, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic        pready, pslverr, rxd, txd_out, txd_oe, irq, e;
    logic [7:0]  b;
    logic [8:0]  g;
    int          error_cnt, comparisons, cyc, dt, dr;
    int          pf[4] = '{1, 3, 4, 13};
    sbd_top #(.AW(12)) sbd_top_i (.*);
    sbd_peer sbd_peer_i (.*);
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task automatic chk(input string n, input logic [31:0] s, x);
        comparisons++;
        if (s !== x)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, x, s);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 64);
        if (n >= 64)
            error_cnt++;
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [7:0] x);
        apb(1'b0, a, 8'h00);
        chk("rdata", r, {24'h0, x});
    endtask : rd
    task automatic ck_irq(input logic v);
        @(posedge pclk);
        chk("irq", {31'h0, irq}, {31'h0, v});
    endtask : ck_irq
    task automatic grab;
        int n;
        n = 0;
        g = 9'h1ff;
        while (sbd_peer_i.cap.size() == 0 && n < 40000)
        begin
            @(posedge pclk);
            n++;
        end
        if (sbd_peer_i.cap.size() > 0)
            g = sbd_peer_i.cap.pop_front();
    endtask : grab
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            error_cnt++;
            tally_and_finish();
        end
    end
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        ce = 1'b1;
        presetn = 1'b0;
        void'($urandom(25885));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(A_CT, 8'h00);
        rd(A_BD, 8'h00);
        apb(1'b1, 12'h14c, 8'hff);
        chk("slverr", {31'h0, e}, 32'h1);
        apb(1'b1, A_CT, 8'hc0);
        ck_irq(1'b1);
        apb(1'b1, A_CT, 8'h0c);
        ck_irq(1'b0);
        for (int k = 0; k < 4; k++)
        begin
            dt = pf[k] << k;
            dr = pf[k] << (3 - k);
            apb(1'b1, A_BD, {k[1:0], k[2:0], 3'(3 - k)});
            sbd_peer_i.blen = 16 * dt;
            b = 8'($urandom) | 8'h01;
            apb(1'b1, A_DP, b);
            grab();
            chk("tx_word", {23'h0, g}, {24'h0, b} | 32'h100);
            chk("start_len", (sbd_peer_i.stlen + dt - 1) / dt, 16);
            b = 8'($urandom);
            sbd_peer_i.send(b, 16 * dr);
            rd(A_DP, b);
        end
        apb(1'b1, A_BD, 8'h00);
        sbd_peer_i.blen = 16;
        apb(1'b1, A_CT, 8'h4c);
        ck_irq(1'b1);
        apb(1'b1, A_CT, 8'h2c);
        ck_irq(1'b0);
        b = 8'($urandom);
        sbd_peer_i.send(b, 16);
        ck_irq(1'b1);
        rd(A_DP, b);
        ck_irq(1'b0);
        apb(1'b1, A_CT, 8'h1c);
        repeat (200) @(posedge pclk);
        ck_irq(1'b1);
        apb(1'b1, A_CT, 8'h0e);
        sbd_peer_i.send(~b, 16);
        repeat (200) @(posedge pclk);
        rd(A_CT, 8'h0c);
        rd(A_DP, b);
        apb(1'b1, A_CT, 8'h08);
        sbd_peer_i.send(~b, 16);
        rd(A_DP, b);
        apb(1'b1, A_CT, 8'h09);
        apb(1'b1, A_CT, 8'h08);
        grab();
        chk("break", {23'h0, g}, 32'h0);
        repeat (400) @(posedge pclk);
        chk("extra", 32'(sbd_peer_i.cap.size()), 32'h0);
        apb(1'b1, A_CT, 8'h00);
        repeat (3) @(posedge pclk);
        chk("pin_own", {31'h0, txd_oe}, 32'h0);
        tally_and_finish();
    end
endmodule : sbd_top_test
bind sbd_top sbd_top_chk #(.AW(AW)) sbd_top_chk_i (.*);

/* File: hdl/sbd_baud_gen.sv */
`timescale 1ns/1ps
`include "sbd_regs.svh"
module sbd_baud_gen (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    sbd_rate_if.gen  rif
);
    import sbd_pkg::*;

    function automatic logic [3:0] pr_max(input logic [1:0] s);
        case (s)
            2'h0:    pr_max = `SBD_PR_MAX_00;
            2'h1:    pr_max = `SBD_PR_MAX_01;
            2'h2:    pr_max = `SBD_PR_MAX_10;
            default: pr_max = `SBD_PR_MAX_11;
        endcase
    endfunction : pr_max

    function automatic logic [6:0] rate_max(input logic [2:0] s);
        rate_max = 7'((8'h01 << s) - 8'h01);
    endfunction : rate_max

    logic [3:0] pr_cnt_q;
    logic       pr_tick;
    logic [2:0] sel [2];
    logic       tick [2];

    // ----------------------------------------
    // first divider
    // ----------------------------------------
    assign pr_tick = ce && (pr_cnt_q >= pr_max(rif.first_divider_select)); // R15

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pr_cnt_q <= 4'h0;
        else if (ce)
            pr_cnt_q <= pr_tick ? 4'h0 : pr_cnt_q + 4'h1;
    end

    // ----------------------------------------
    // rate dividers
    // ----------------------------------------
    assign sel[0] = rif.tx_rate_select;
    assign sel[1] = rif.rx_rate_select;

    for (genvar i = 0; i < 2; i++)
    begin : g_rate
        logic [6:0] cnt_q;
        assign tick[i] = pr_tick && (cnt_q >= rate_max(sel[i])); // R16 R17
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                cnt_q <= 7'h00;
            else if (pr_tick)
                cnt_q <= tick[i] ? 7'h00 : cnt_q + 7'h01;
        end
    end

    assign rif.tx_tick = tick[0];
    assign rif.rx_tick = tick[1];
endmodule : sbd_baud_gen

/* File: hdl/sbd_pkg.sv */
package sbd_pkg;
    typedef enum logic [5:0] {
        TX_OFF  = 6'h01,
        TX_WAIT = 6'h02,
        TX_IDLE = 6'h04,
        TX_DATA = 6'h08,
        TX_PRE  = 6'h10,
        TX_BRK  = 6'h20
    } sbd_tx_st_t;
    typedef enum logic [4:0] {
        RX_OFF   = 5'h01,
        RX_HUNT  = 5'h02,
        RX_START = 5'h04,
        RX_DATA  = 5'h08,
        RX_STOP  = 5'h10
    } sbd_rx_st_t;
endpackage : sbd_pkg

/* File: hdl/sbd_rate_if.sv */
`timescale 1ns/1ps
interface sbd_rate_if;
    logic [1:0] first_divider_select;
    logic [2:0] tx_rate_select;
    logic [2:0] rx_rate_select;
    logic       tx_tick;
    logic       rx_tick;
    modport gen (
        input  first_divider_select,
        input  tx_rate_select,
        input  rx_rate_select,
        output tx_tick,
        output rx_tick
    );
    modport use_side (
        output first_divider_select,
        output tx_rate_select,
        output rx_rate_select,
        input  tx_tick,
        input  rx_tick
    );
endinterface : sbd_rate_if

/* File: hdl/sbd_regs.svh */
// What this block does
// R01 - tx empty enable gates irq
// R02 - tx complete enable gates irq
// R03 - rx enable: overrun or full irq
// R04 - idle enable gates irq
// R05 - transmitter runs only with tx_enable
// R06 - tx_enable pulse mid word: preamble
// R07 - one bit wait after enable
// R08 - pin freed when both enables clear
// R09 - rx_enable starts start bit hunt
// R10 - receive data before setting mute
// R11 - mute bit; wakeup clears it
// R12 - break_send high sends breaks
// R13 - break pulse sends one break
// R14 - data port: rx read, tx write
// R15 - first divider select: 1,3,4,13
// R16 - tx rate: first divider times 2^n
// R17 - rx rate: first divider times 2^n
// R18 - enabled conditions ORed to irq
`ifndef SBD_REGS_SVH
`define SBD_REGS_SVH
// ----------------------------------------
// register indices
// ----------------------------------------
`define SBD_IDX_STATUS   8'h50
`define SBD_IDX_DATA     8'h51
`define SBD_IDX_BAUD     8'h52
`define SBD_IDX_CTRL     8'h54
`define SBD_RST_CTRL     8'h00
`define SBD_RST_BAUD     8'h00
// ----------------------------------------
// control_two fields
// ----------------------------------------
`define SBD_B_TXE_IRQ    7
`define SBD_B_TXC_IRQ    6
`define SBD_B_RX_IRQ     5
`define SBD_B_IDLE_IRQ   4
`define SBD_B_TX_EN      3
`define SBD_B_RX_EN      2
`define SBD_B_MUTE       1
`define SBD_B_BRK        0
// ----------------------------------------
// baud_select fields
// ----------------------------------------
`define SBD_F_PR_HI      7
`define SBD_F_PR_LO      6
`define SBD_F_TR_HI      5
`define SBD_F_TR_LO      3
`define SBD_F_RR_HI      2
`define SBD_F_RR_LO      0
`define SBD_PR_MAX_00    4'h0
`define SBD_PR_MAX_01    4'h2
`define SBD_PR_MAX_10    4'h3
`define SBD_PR_MAX_11    4'hc
// ----------------------------------------
// timing counts
// ----------------------------------------
`define SBD_OVS_LAST     4'hf
`define SBD_OVS_MID      4'h7
`define SBD_FRAME_BITS   4'ha
`define SBD_IDLE_TICKS   8'h9f
`endif

/* File: hdl/sbd_rx.sv */
`timescale 1ns/1ps
`include "sbd_regs.svh"
module sbd_rx (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ce,
    input  wire logic       rx_tick,
    input  wire logic       rx_enable,
    input  wire logic       rxd,
    output logic [7:0]      rx_data,
    output logic            rx_done,
    output logic            rx_idle
);
    import sbd_pkg::*;

    sbd_rx_st_t st_q;
    logic [3:0] sub_q;
    logic [2:0] bit_q;
    logic [7:0] sh_q;
    logic [7:0] idle_q;
    logic       armed_q;
    logic       last;

    assign last = rx_tick && (sub_q == `SBD_OVS_LAST);

    // ----------------------------------------
    // frame state
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q  <= RX_OFF;
            sub_q <= 4'h0;
            bit_q <= 3'h0;
            sh_q  <= 8'h00;
        end
        else if (ce)
        begin
            if (rx_tick)
                sub_q <= sub_q + 4'h1;
            case (st_q)
                RX_OFF:
                    if (rx_enable)
                        st_q <= RX_HUNT; // R09
                RX_HUNT:
                    if (rx_tick && !rxd)
                    begin
                        st_q  <= RX_START;
                        sub_q <= 4'h0;
                    end
                RX_START:
                    if (rx_tick && sub_q == `SBD_OVS_MID)
                    begin
                        st_q  <= rxd ? RX_HUNT : RX_DATA;
                        sub_q <= 4'h0;
                        bit_q <= 3'h0;
                    end
                RX_DATA:
                    if (last)
                    begin
                        sh_q  <= {rxd, sh_q[7:1]};
                        bit_q <= bit_q + 3'h1;
                        if (bit_q == 3'h7)
                            st_q <= RX_STOP;
                    end
                RX_STOP:
                    if (last)
                        st_q <= RX_HUNT;
                default:
                    st_q <= RX_OFF;
            endcase
            if (!rx_enable)
                st_q <= RX_OFF; // R09
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_data <= 8'h00;
            rx_done <= 1'b0;
        end
        else if (ce)
        begin
            rx_done <= rx_enable && st_q == RX_STOP && last && rxd;
            if (st_q == RX_STOP && last && rxd)
                rx_data <= sh_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            idle_q  <= 8'h00;
            armed_q <= 1'b0;
            rx_idle <= 1'b0;
        end
        else if (ce)
        begin
            rx_idle <= 1'b0;
            if (st_q != RX_HUNT || !rxd)
                idle_q <= 8'h00;
            else if (rx_tick && idle_q != `SBD_IDLE_TICKS)
                idle_q <= idle_q + 8'h01;
            if (rx_done)
                armed_q <= 1'b1;
            else if (armed_q && rx_tick && idle_q == `SBD_IDLE_TICKS)
            begin
                armed_q <= 1'b0;
                rx_idle <= 1'b1;
            end
        end
    end
endmodule : sbd_rx

/* File: hdl/sbd_top.sv */
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "sbd_regs.svh"
module sbd_top #(
    parameter int AW = 12
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          ce,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [AW-1:0] paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          rxd,
    output logic               txd_out,
    output logic               txd_oe,
    output logic               irq
);
    import sbd_pkg::*;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    function automatic logic [3:0] reg_sel(input logic [AW-1:0] a);
        reg_sel[0] = a == AW'({`SBD_IDX_STATUS, 2'b00});
        reg_sel[1] = a == AW'({`SBD_IDX_DATA, 2'b00});
        reg_sel[2] = a == AW'({`SBD_IDX_BAUD, 2'b00});
        reg_sel[3] = a == AW'({`SBD_IDX_CTRL, 2'b00});
    endfunction : reg_sel

    logic [7:0]  control_two_q;
    logic [7:0]  baud_select_q;
    logic [7:0]  tx_holding_reg_q;
    logic [7:0]  rx_holding_reg_q;
    logic [31:0] prdata_q;
    logic        ph_q;
    logic [3:0]  sel;
    logic        acc;
    logic        wr_data;
    logic        rd_data;
    logic        wr_ctrl;
    logic        tx_empty_flag_q;
    logic        tx_complete_flag_q;
    logic        rx_full_flag_q;
    logic        idle_flag_q;
    logic        overrun_flag_q;
    logic [7:0]  status_flags;
    logic        tx_enable;
    logic        rx_enable;
    logic        rx_mute;
    logic        break_send;
    logic        tx_seen_q;
    logic        pre_pend_q;
    logic        brk_pend_q;
    sbd_tx_st_t  tx_q;
    logic [3:0]  sub_q;
    logic [3:0]  bits_q;
    logic [9:0]  txs_q;
    logic        bit_end;
    logic        word_end;
    logic        tx_busy;
    logic        load_data;
    logic [7:0]  rx_byte;
    logic        rx_done;
    logic        rx_idle;
    logic        rx_take;

    sbd_rate_if rif ();

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    assign sel     = reg_sel(paddr);
    assign pready  = ce && ph_q;
    assign pslverr = acc && (sel == 4'h0);
    assign prdata  = prdata_q;
    assign acc     = psel && penable && pready;
    assign wr_data = acc && pwrite && sel[1];
    assign rd_data = acc && !pwrite && sel[1];
    assign wr_ctrl = acc && pwrite && sel[3];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ph_q <= 1'b0;
        else if (ce)
            ph_q <= psel && !(penable && ph_q);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= 32'h0000_0000;
        else if (ce && psel && !ph_q)
        begin
            case (1'b1)
                sel[0]:  prdata_q <= 32'(status_flags);
                sel[1]:  prdata_q <= 32'(rx_holding_reg_q); // R14
                sel[2]:  prdata_q <= 32'(baud_select_q);
                sel[3]:  prdata_q <= 32'(control_two_q);
                default: prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // control and baud registers
    // ----------------------------------------
    assign tx_enable  = control_two_q[`SBD_B_TX_EN];
    assign rx_enable  = control_two_q[`SBD_B_RX_EN];
    assign rx_mute    = control_two_q[`SBD_B_MUTE];
    assign break_send = control_two_q[`SBD_B_BRK];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            control_two_q <= `SBD_RST_CTRL;
        else if (ce)
        begin
            if (wr_ctrl)
                control_two_q <= pwdata[7:0]; // R05
            // wakeup beats write
            if (rx_idle)
                control_two_q[`SBD_B_MUTE] <= 1'b0; // R11
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            baud_select_q <= `SBD_RST_BAUD;
        else if (ce && acc && pwrite && sel[2])
            baud_select_q <= pwdata[7:0];
    end

    assign rif.first_divider_select =
        baud_select_q[`SBD_F_PR_HI:`SBD_F_PR_LO]; // R15
    assign rif.tx_rate_select =
        baud_select_q[`SBD_F_TR_HI:`SBD_F_TR_LO]; // R16
    assign rif.rx_rate_select =
        baud_select_q[`SBD_F_RR_HI:`SBD_F_RR_LO]; // R17

    sbd_baud_gen u_baud (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .rif     (rif)
    );

    // ----------------------------------------
    // transmit holding register
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tx_holding_reg_q <= 8'h00;
        else if (ce && wr_data)
            tx_holding_reg_q <= pwdata[7:0]; // R14
    end

    // ----------------------------------------
    // pending events
    // ----------------------------------------
    assign tx_busy = tx_q inside {TX_DATA, TX_PRE, TX_BRK};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pre_pend_q <= 1'b0;
            brk_pend_q <= 1'b0;
            tx_seen_q  <= 1'b0;
        end
        else if (ce)
        begin
            if (tx_enable)
                tx_seen_q <= 1'b1;
            if (wr_ctrl && tx_busy && !tx_enable && pwdata[`SBD_B_TX_EN])
                pre_pend_q <= 1'b1; // R06
            else if (tx_q == TX_PRE)
                pre_pend_q <= 1'b0;
            if (wr_ctrl && pwdata[`SBD_B_BRK] && !break_send)
                brk_pend_q <= 1'b1; // R13
            else if (tx_q == TX_BRK)
                brk_pend_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // transmit shifter
    // ----------------------------------------
    assign bit_end   = rif.tx_tick && (sub_q == `SBD_OVS_LAST);
    assign word_end  = tx_busy && bit_end && (bits_q == 4'h1);
    assign load_data = (tx_q == TX_IDLE) && tx_enable && !break_send
                       && !brk_pend_q && !pre_pend_q && !tx_empty_flag_q
                       && !wr_data;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_q   <= TX_OFF;
            sub_q  <= 4'h0;
            bits_q <= 4'h0;
            txs_q  <= 10'h3ff;
        end
        else if (ce)
        begin
            if (rif.tx_tick)
                sub_q <= sub_q + 4'h1;
            case (tx_q)
                TX_OFF:
                    if (tx_enable)
                    begin
                        tx_q  <= TX_WAIT; // R07
                        sub_q <= 4'h0;
                    end
                TX_WAIT:
                    if (!tx_enable)
                        tx_q <= TX_OFF;
                    else if (bit_end)
                        tx_q <= TX_IDLE; // R07
                TX_IDLE:
                begin
                    sub_q  <= 4'h0;
                    bits_q <= `SBD_FRAME_BITS;
                    if (!tx_enable)
                        tx_q <= TX_OFF; // R05
                    else if (break_send || brk_pend_q)
                    begin
                        tx_q  <= TX_BRK; // R12
                        txs_q <= 10'h000;
                    end
                    else if (pre_pend_q)
                    begin
                        tx_q  <= TX_PRE; // R06
                        txs_q <= 10'h3ff;
                    end
                    else if (load_data)
                    begin
                        tx_q  <= TX_DATA;
                        txs_q <= {1'b1, tx_holding_reg_q, 1'b0};
                    end
                end
                TX_DATA, TX_PRE, TX_BRK:
                    if (bit_end)
                    begin
                        txs_q  <= {tx_q != TX_BRK, txs_q[9:1]};
                        bits_q <= bits_q - 4'h1;
                        if (word_end)
                            tx_q <= TX_IDLE;
                    end
                default:
                    tx_q <= TX_OFF;
            endcase
        end
    end

    // ----------------------------------------
    // serial output pin
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            txd_out <= 1'b1;
            txd_oe  <= 1'b0;
        end
        else if (ce)
        begin
            txd_out <= tx_busy ? txs_q[0] : 1'b1;
            txd_oe  <= tx_seen_q && (tx_enable || rx_enable); // R08
        end
    end

    // ----------------------------------------
    // transmit flags
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_empty_flag_q    <= 1'b1;
            tx_complete_flag_q <= 1'b1;
        end
        else if (ce)
        begin
            if (load_data)
                tx_empty_flag_q <= 1'b1;
            else if (wr_data)
                tx_empty_flag_q <= 1'b0;
            if (word_end && tx_empty_flag_q && !break_send
                && !brk_pend_q && !pre_pend_q)
                tx_complete_flag_q <= 1'b1;
            else if (wr_data)
                tx_complete_flag_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // receiver
    // ----------------------------------------
    sbd_rx u_rx (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .rx_tick   (rif.rx_tick),
        .rx_enable (rx_enable),
        .rxd       (rxd),
        .rx_data   (rx_byte),
        .rx_done   (rx_done),
        .rx_idle   (rx_idle)
    );

    assign rx_take = rx_done && !rx_mute; // R11

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rx_holding_reg_q <= 8'h00;
        else if (ce && rx_take && (!rx_full_flag_q || rd_data))
            rx_holding_reg_q <= rx_byte; // R14
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_full_flag_q <= 1'b0;
            overrun_flag_q <= 1'b0;
            idle_flag_q    <= 1'b0;
        end
        else if (ce)
        begin
            if (rx_take)
                rx_full_flag_q <= 1'b1;
            else if (rd_data)
                rx_full_flag_q <= 1'b0;
            if (rx_take && rx_full_flag_q && !rd_data)
                overrun_flag_q <= 1'b1;
            else if (rd_data)
                overrun_flag_q <= 1'b0;
            if (rx_idle && !rx_mute)
                idle_flag_q <= 1'b1;
            else if (rd_data)
                idle_flag_q <= 1'b0;
        end
    end

    assign status_flags = {tx_empty_flag_q, tx_complete_flag_q,
                           rx_full_flag_q, idle_flag_q,
                           overrun_flag_q, 3'b000};

    // ----------------------------------------
    // interrupt request
    // ----------------------------------------
    always_comb
    begin
        irq = 1'b0;
        if (control_two_q[`SBD_B_TXE_IRQ] && tx_empty_flag_q)
            irq = 1'b1; // R01
        if (control_two_q[`SBD_B_TXC_IRQ] && tx_complete_flag_q)
            irq = 1'b1; // R02
        if (control_two_q[`SBD_B_RX_IRQ]
            && (overrun_flag_q || rx_full_flag_q))
            irq = 1'b1; // R03
        if (control_two_q[`SBD_B_IDLE_IRQ] && idle_flag_q)
            irq = 1'b1; // R04 R18
    end
endmodule : sbd_top
